// >>> verilog/pwm_timing_pkg.sv
/*
  Constants, register offsets, reset values and state codes for the three-phase center-based PWM timing unit.
  Assumes one clock domain and a simple strobe-based register port driven by a processor core.
*/
// Operation
// - Phase A, B and C output pairs each follow their own duty count.
// - Duty count is high-side on-time per half period, in clock periods.
// - Single update mode gives waveforms symmetrical about the period middle.
// - Dead time shifts every switching edge by dead-time count clock periods.
// - Single mode: high time 2*(duty-dead), low time 2*(half-duty-dead).
// - On-times clamp between zero and the half period.
// - Double mode: high time is sum of both half duties minus both dead times.
// - Double mode: period equals first half count plus second half count.
// - Double mode inserts dead time exactly as single mode does.
// - Single mode uses the same duty values for both half cycles.
// - No outputs until half period and three duties are written; then start.
// - Single mode: first sync about 1.5 half-periods after the half-period write.
// - Double mode: first sync one half-period after the half-period write.
// - Status bit 3 shows which half of the period is active.
// - Duty step of one changes on-time one clock per half period.
// - Minimum on-time per half period is min-pulse count clock periods.
// - Pulses shorter than minimum are deleted; complement held fully on.
// - Every timing quantity is an integer count of the single clock period.
// - Mode bit 6 selects double update; single update after reset.
// - Double mode adds a midpoint sync; values latch at each sync start.
// - Sync pulse lasts width count plus one clocks; width resets to 0x27.
// - Half-period count is the number of clocks in half a PWM period.
package pwm_timing_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int DT_W   = 10;
  localparam int SW_W   = 8;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_DUTY_A     = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_B     = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_C     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_HALF_PER   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_DEAD_TIME  = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MIN_PULSE  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_WIDTH = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL  = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_SYS_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int                MODE_DOUBLE_BIT = 6;
  localparam int                STATUS_HALF_BIT = 3;
  localparam int                STATUS_RUN_BIT  = 0;
  localparam logic [SW_W-1:0]   RST_SYNC_WIDTH  = 8'h27;
  localparam logic [DATA_W-1:0] RST_COUNT       = 16'h0000;
  localparam logic [3:0]        INIT_ALL_DONE   = 4'hF;

  // ----------------------------------------------------------------
  // Run states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;

endpackage : pwm_timing_pkg

// >>> verilog/three_phase_center_pwm_timing.sv
/*
  Three-phase center-based PWM timing unit: duty, half-period, dead-time, minimum-pulse and sync-width
  registers, single/double update modes, narrow pulse deletion and the cycle sync pulse.
  Assumes a processor core on the same clock driving one-cycle read/write strobes, and an output control
  stage downstream that handles crossover, per-output disable and shutdown.
*/
// Chosen here: the register addresses and the plain strobed port.
module three_phase_center_pwm_timing (
  // Clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  // Register port
  input  wire logic [pwm_timing_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pwm_timing_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [pwm_timing_pkg::DATA_W-1:0]  reg_rdata,
  // Timing unit outputs
  output logic                                    phase_a_high_out,
  output logic                                    phase_a_low_out,
  output logic                                    phase_b_high_out,
  output logic                                    phase_b_low_out,
  output logic                                    phase_c_high_out,
  output logic                                    phase_c_low_out,
  output logic                                    cycle_sync_pulse
);
  import pwm_timing_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    run_state_t                 st;
    logic [2:0][DATA_W-1:0]     duty;
    logic [DATA_W-1:0]          hp;
    logic [DT_W-1:0]            dt;
    logic [DATA_W-1:0]          pd;
    logic [SW_W-1:0]            sw;
    logic                       dbl_mode;
    logic [3:0]                 written;
    logic [2:0][DATA_W-1:0]     duty_l;
    logic [DATA_W-1:0]          hp_l;
    logic [DT_W-1:0]            dt_l;
    logic [DATA_W-1:0]          pd_l;
    logic [SW_W-1:0]            sw_l;
    logic                       dbl_l;
    logic [DATA_W-1:0]          cnt;
    logic                       half;
    logic [SW_W:0]              sync_left;
    logic                       sync_out;
    logic [5:0]                 outs;
    logic [DATA_W-1:0]          rdata;
  } state_t;

  localparam state_t S_RST = '{st: ST_IDLE, sw: RST_SYNC_WIDTH, default: '0};

  state_t s_reg;
  state_t s_next;

  logic [2:0]             hi_on;
  logic [2:0]             lo_on;
  logic [2:0][DATA_W-1:0] hi_len;
  logic [2:0][DATA_W-1:0] lo_len;

  // ----------------------------------------------------------------
  // Per-phase edge placement
  // ----------------------------------------------------------------
  // Widened signed math so that duty below dead time, or duty plus dead time above the half
  // period, gives a negative length that clamps to zero instead of wrapping.
  for (genvar i = 0; i < 3; i++)
  begin : g_phase
    logic signed [DATA_W+1:0] hi_raw;
    logic signed [DATA_W+1:0] lo_raw;
    logic signed [DATA_W+1:0] hp_s;
    logic signed [DATA_W+1:0] dt_s;
    logic        [DATA_W-1:0] hi_c;
    logic        [DATA_W-1:0] lo_c;
    logic                     hi_short;
    logic                     lo_short;

    assign hp_s   = $signed({2'b00, s_reg.hp_l});
    assign dt_s   = $signed({{(DATA_W + 2 - DT_W){1'b0}}, s_reg.dt_l});
    assign hi_raw = $signed({2'b00, s_reg.duty_l[i]}) - dt_s;
    assign lo_raw = hp_s - $signed({2'b00, s_reg.duty_l[i]}) - dt_s;

    assign hi_c = (hi_raw < 0) ? RST_COUNT : ((hi_raw > hp_s) ? s_reg.hp_l : hi_raw[DATA_W-1:0]);
    assign lo_c = (lo_raw < 0) ? RST_COUNT : ((lo_raw > hp_s) ? s_reg.hp_l : lo_raw[DATA_W-1:0]);

    // Short high pulse wins: the low side is then held on for the whole half
    assign hi_short = (hi_c < s_reg.pd_l);
    assign lo_short = (lo_c < s_reg.pd_l);

    assign hi_len[i] = hi_short ? RST_COUNT : (lo_short ? s_reg.hp_l : hi_c);
    assign lo_len[i] = hi_short ? s_reg.hp_l : (lo_short ? RST_COUNT : lo_c);

    // High pulse hugs the period centre, low pulse hugs the period ends
    assign hi_on[i] = s_reg.half ? (s_reg.cnt < hi_len[i])
                                 : (s_reg.cnt >= (s_reg.hp_l - hi_len[i]));
    assign lo_on[i] = s_reg.half ? (s_reg.cnt >= (s_reg.hp_l - lo_len[i]))
                                 : (s_reg.cnt < lo_len[i]);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic              last;
    logic              latch;
    logic [DATA_W-1:0] status;
    last   = 1'b0;
    latch  = 1'b0;
    status = '0;
    s_next = s_reg;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_DUTY_A:
        begin
          s_next.duty[0]    = reg_wdata;
          s_next.written[0] = 1'b1;
        end
        ADDR_DUTY_B:
        begin
          s_next.duty[1]    = reg_wdata;
          s_next.written[1] = 1'b1;
        end
        ADDR_DUTY_C:
        begin
          s_next.duty[2]    = reg_wdata;
          s_next.written[2] = 1'b1;
        end
        ADDR_HALF_PER:
        begin
          s_next.hp         = reg_wdata;
          s_next.written[3] = 1'b1;
        end
        ADDR_DEAD_TIME:  s_next.dt       = reg_wdata[DT_W-1:0];
        ADDR_MIN_PULSE:  s_next.pd       = reg_wdata;
        ADDR_SYNC_WIDTH: s_next.sw       = reg_wdata[SW_W-1:0];
        ADDR_MODE_CTRL:  s_next.dbl_mode = reg_wdata[MODE_DOUBLE_BIT];
        default:         s_next.written  = s_reg.written;
      endcase
    end

    // Register reads, data valid in the following cycle
    status[STATUS_HALF_BIT] = s_reg.half;
    status[STATUS_RUN_BIT]  = (s_reg.st == ST_RUN);
    s_next.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_DUTY_A:     s_next.rdata = s_reg.duty[0];
        ADDR_DUTY_B:     s_next.rdata = s_reg.duty[1];
        ADDR_DUTY_C:     s_next.rdata = s_reg.duty[2];
        ADDR_HALF_PER:   s_next.rdata = s_reg.hp;
        ADDR_DEAD_TIME:  s_next.rdata = {{(DATA_W - DT_W){1'b0}}, s_reg.dt};
        ADDR_MIN_PULSE:  s_next.rdata = s_reg.pd;
        ADDR_SYNC_WIDTH: s_next.rdata = {{(DATA_W - SW_W){1'b0}}, s_reg.sw};
        ADDR_MODE_CTRL:  s_next.rdata[MODE_DOUBLE_BIT] = s_reg.dbl_mode;
        ADDR_SYS_STATUS: s_next.rdata = status;
        default:         s_next.rdata = '0;
      endcase
    end

    // Sync pulse countdown
    if (s_reg.sync_left != '0)
      s_next.sync_left = s_reg.sync_left - 1'b1;

    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (s_next.written == INIT_ALL_DONE)
        begin
          s_next.st     = ST_RUN;
          s_next.duty_l = s_next.duty;
          s_next.hp_l   = s_next.hp;
          s_next.dt_l   = s_next.dt;
          s_next.pd_l   = s_next.pd;
          s_next.sw_l   = s_next.sw;
          s_next.dbl_l  = s_next.dbl_mode;
          // Lead-in: single mode starts mid first half, double at second half start
          if (s_next.dbl_mode)
          begin
            s_next.half = 1'b1;
            s_next.cnt  = RST_COUNT;
          end
          else
          begin
            s_next.half = 1'b0;
            s_next.cnt  = s_next.hp >> 1;
          end
        end
      end
      ST_RUN:
      begin
        last = ({1'b0, s_reg.cnt} + 17'd1) >= {1'b0, s_reg.hp_l};
        if (last)
        begin
          s_next.cnt  = RST_COUNT;
          s_next.half = ~s_reg.half;
          // Period start always latches; the midpoint latches only in double mode
          latch = s_reg.half || s_reg.dbl_mode;
        end
        else
          s_next.cnt = s_reg.cnt + 1'b1;
        if (latch)
        begin
          s_next.duty_l    = s_next.duty;
          s_next.hp_l      = s_next.hp;
          s_next.dt_l      = s_next.dt;
          s_next.pd_l      = s_next.pd;
          s_next.sw_l      = s_next.sw;
          s_next.dbl_l     = s_next.dbl_mode;
          s_next.sync_left = (SW_W + 1)'({1'b0, s_next.sw} + 9'd1);
        end
      end
    endcase

    // One cycle behind the counter, like the gate outputs, so sync and pattern stay aligned
    s_next.sync_out = (s_reg.sync_left != '0);
    if (s_reg.st == ST_RUN)
    begin
      for (int k = 0; k < 3; k++)
      begin
        s_next.outs[2*k]   = hi_on[k];
        s_next.outs[2*k+1] = lo_on[k];
      end
    end
    else
      s_next.outs = '0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_reg <= S_RST;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata        = s_reg.rdata;
  assign phase_a_high_out = s_reg.outs[0];
  assign phase_a_low_out  = s_reg.outs[1];
  assign phase_b_high_out = s_reg.outs[2];
  assign phase_b_low_out  = s_reg.outs[3];
  assign phase_c_high_out = s_reg.outs[4];
  assign phase_c_low_out  = s_reg.outs[5];
  assign cycle_sync_pulse = s_reg.sync_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Helper: length of the current high run of the sync pulse
  logic [SW_W+1:0] sync_len;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sync_len <= '0;
    else if (s_reg.sync_out)
      sync_len <= sync_len + 1'b1;
    else
      sync_len <= '0;
  end

  property p_idle_off;
    @(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_IDLE) |-> (s_reg.outs == 6'h00) && !s_reg.sync_out;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("outputs active before init");

  property p_no_overlap;
    @(posedge core_clk) disable iff (rst)
    !(phase_a_high_out && phase_a_low_out) && !(phase_b_high_out && phase_b_low_out)
      && !(phase_c_high_out && phase_c_low_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("high and low side on together");

  property p_sync_width;
    @(posedge core_clk) disable iff (rst)
    $fell(s_reg.sync_out) |-> (sync_len == ({2'b00, $past(s_reg.sw_l)} + 10'd1));
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync pulse width wrong");

  property p_sync_cause;
    @(posedge core_clk) disable iff (rst)
    $rose(s_reg.sync_out) |-> ($past(s_reg.cnt) == RST_COUNT) && $past(s_reg.st == ST_RUN);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync not at half boundary");

  property p_single_sync_half;
    @(posedge core_clk) disable iff (rst)
    ($rose(s_reg.sync_out) && !s_reg.dbl_l) |-> !$past(s_reg.half);
  endproperty
  a_single_sync_half: assert property (p_single_sync_half) else $error("single mode sync at midpoint");

  property p_single_hold;
    @(posedge core_clk) disable iff (rst)
    ($changed(s_reg.duty_l) && $past(s_reg.st == ST_RUN)) |-> (!s_reg.half || s_reg.dbl_l);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("duty latched mid period in single mode");

  property p_deleted_high;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && (hi_len[0] == RST_COUNT)) |=> !phase_a_high_out;
  endproperty
  a_deleted_high: assert property (p_deleted_high) else $error("deleted high pulse appeared");

  property p_full_low;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && (s_reg.pd_l != RST_COUNT) && (hi_len[0] < s_reg.pd_l)) |=> phase_a_low_out;
  endproperty
  a_full_low: assert property (p_full_low) else $error("complement not fully on");

  property p_start_phase;
    @(posedge core_clk) disable iff (rst)
    ($past(s_reg.st == ST_IDLE) && (s_reg.st == ST_RUN))
      |-> (s_reg.dbl_l ? (s_reg.half && (s_reg.cnt == RST_COUNT))
                       : (!s_reg.half && (s_reg.cnt == (s_reg.hp_l >> 1))));
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("wrong lead-in after init");

  property p_cnt_range;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && (s_reg.hp_l != RST_COUNT)) |-> (s_reg.cnt < s_reg.hp_l);
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("half counter beyond half period");

  property p_len_clamp;
    @(posedge core_clk) disable iff (rst)
    (s_reg.st == ST_RUN) |-> (hi_len[1] <= s_reg.hp_l) && (lo_len[1] <= s_reg.hp_l);
  endproperty
  a_len_clamp: assert property (p_len_clamp) else $error("on-time beyond half period");

  // Without clamping or deletion, both on-times and two dead times fill the half exactly
  property p_dead_sum;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && (s_reg.pd_l == RST_COUNT) && ({2'h0, s_reg.duty_l[0]} >= {8'h00, s_reg.dt_l})
      && (({2'h0, s_reg.duty_l[0]} + {8'h00, s_reg.dt_l}) <= {2'h0, s_reg.hp_l}))
      |-> (({2'h0, hi_len[0]} + {2'h0, lo_len[0]} + {7'h00, s_reg.dt_l, 1'h0}) == {2'h0, s_reg.hp_l});
  endproperty
  a_dead_sum: assert property (p_dead_sum) else $error("dead time not taken from both sides");

  property p_start_cond;
    @(posedge core_clk) disable iff (rst)
    ($past(s_reg.st == ST_IDLE) && (s_reg.st == ST_RUN)) |-> (s_reg.written == INIT_ALL_DONE);
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("timer started before init writes");

  property p_status_half;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && (reg_addr == ADDR_SYS_STATUS)) |=> (reg_rdata[STATUS_HALF_BIT] == $past(s_reg.half));
  endproperty
  a_status_half: assert property (p_status_half) else $error("status half bit wrong");

  property p_low_deleted;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && (lo_len[2] == RST_COUNT)) |=> !phase_c_low_out;
  endproperty
  a_low_deleted: assert property (p_low_deleted) else $error("deleted low pulse appeared");

  property p_hp_latch;
    @(posedge core_clk) disable iff (rst)
    ($changed(s_reg.hp_l) && $past(s_reg.st == ST_RUN)) |-> (s_reg.cnt == RST_COUNT);
  endproperty
  a_hp_latch: assert property (p_hp_latch) else $error("half period latched off boundary");

  property p_mid_sync;
    @(posedge core_clk) disable iff (rst)
    ((s_reg.st == ST_RUN) && s_reg.dbl_mode && !s_reg.half && (({1'h0, s_reg.cnt} + 17'h00001) >= {1'h0, s_reg.hp_l}))
      |-> ##2 s_reg.sync_out;
  endproperty
  a_mid_sync: assert property (p_mid_sync) else $error("no midpoint sync in double mode");

endmodule : three_phase_center_pwm_timing

// >>> testbench/gate_drive_monitor.sv
/*
  Gate driver side model: watches the six timing-unit outputs and the sync pulse and measures
  each sync interval (length, on-cycles per output) and the width of each sync pulse.
  Assumes registered outputs on core_clk; index order 0..5 is A high, A low, B high, B low, C high, C low.
*/
module gate_drive_monitor (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Timing unit outputs
  input  wire logic [5:0]  gate_in,
  input  wire logic        sync_in,
  // Measurements, refreshed at each sync rising edge; sync_w_seen at each sync falling edge
  output logic      [15:0] len_seen,
  output logic      [15:0] on_seen [6],
  output logic      [15:0] sync_w_seen,
  output logic      [15:0] sync_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        sync_d;
  logic [15:0] len_acc;
  logic [15:0] on_acc [6];
  logic [15:0] w_acc;

  // ----------------------------------------------------------------
  // Interval measurement
  // ----------------------------------------------------------------
  // An interval runs from one sync rising edge to the next, so a whole half or period is seen
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_d      <= 1'b0;
      len_acc     <= 16'h0000;
      len_seen    <= 16'h0000;
      sync_seen   <= 16'h0000;
      sync_w_seen <= 16'h0000;
      w_acc       <= 16'h0000;
      for (int i = 0; i < 6; i++)
      begin
        on_acc[i]  <= 16'h0000;
        on_seen[i] <= 16'h0000;
      end
    end
    else
    begin
      sync_d <= sync_in;
      if (sync_in && !sync_d)
      begin
        len_seen  <= len_acc;
        sync_seen <= sync_seen + 16'h0001;
        len_acc   <= 16'h0001;
      end
      else
        len_acc <= len_acc + 16'h0001;
      for (int i = 0; i < 6; i++)
      begin
        if (sync_in && !sync_d)
        begin
          on_seen[i] <= on_acc[i];
          on_acc[i]  <= {15'h0000, gate_in[i]};
        end
        else
          on_acc[i] <= on_acc[i] + {15'h0000, gate_in[i]};
      end
      if (sync_in)
        w_acc <= w_acc + 16'h0001;
      else if (sync_d)
      begin
        sync_w_seen <= w_acc;
        w_acc       <= 16'h0000;
      end
    end
  end
endmodule : gate_drive_monitor

// >>> testbench/three_phase_center_pwm_timing_bench.sv
/*
  Self-checking bench for the three-phase PWM timing unit: start-up gating, on-times in both update
  modes, clamping, narrow pulse deletion, sync spacing and width, half indication.
  Assumes the gate_drive_monitor model and a 25 MHz core_clk.
*/
module three_phase_center_pwm_timing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pwm_timing_pkg::*;

  logic              core_clk;
  logic              rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [5:0]        gate;
  logic              cycle_sync_pulse;
  logic [15:0]       len_seen;
  logic [15:0]       on_seen [6];
  logic [15:0]       sync_w_seen;
  logic [15:0]       sync_seen;
  int                fail_count;
  int                checked;

  three_phase_center_pwm_timing i_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_high_out(gate[0]), .phase_a_low_out(gate[1]),
    .phase_b_high_out(gate[2]), .phase_b_low_out(gate[3]), .phase_c_high_out(gate[4]),
    .phase_c_low_out(gate[5]), .cycle_sync_pulse(cycle_sync_pulse));

  gate_drive_monitor i_drv (
    .core_clk(core_clk), .rst(rst), .gate_in(gate), .sync_in(cycle_sync_pulse), .len_seen(len_seen),
    .on_seen(on_seen), .sync_w_seen(sync_w_seen), .sync_seen(sync_seen));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk

  // Start-up latency is only loosely fixed, so a small window is allowed
  task automatic chk_near(input string n, input int e, input int s);
    checked++;
    if (s < e - 4 || s > e + 4)
    begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk_near

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic wait_sync(input int n);
    logic [15:0] old;
    int          k;
    repeat (n)
    begin
      old = sync_seen;
      k = 0;
      while (sync_seen === old && k < 200)
      begin
        @(posedge core_clk);
        #1;
        k++;
      end
      if (k >= 200)
        chk("sync arrival", 16'h0000, 16'hFFFF);
    end
  endtask : wait_sync

  task automatic first_sync(input int e);
    int k;
    k = 0;
    while (cycle_sync_pulse !== 1'b1 && k < 1000)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk_near("first sync delay", e, k);
  endtask : first_sync

  task automatic chk_pairs(input logic [15:0] ah, al, bh, bl, chh, cl);
    chk("a high on", ah, on_seen[0]);
    chk("a low on", al, on_seen[1]);
    chk("b high on", bh, on_seen[2]);
    chk("b low on", bl, on_seen[3]);
    chk("c high on", chh, on_seen[4]);
    chk("c low on", cl, on_seen[5]);
  endtask : chk_pairs

  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [15:0] v;
    rd(ADDR_SYNC_WIDTH, v);
    chk("sync width reset", 16'h0027, v);
    rd(ADDR_MODE_CTRL, v);
    chk("mode reset", 16'h0000, v);
    wr(4'hC, 16'h1234);
    rd(4'hC, v);
    chk("unmapped read", 16'h0000, v);
  endtask : t_defaults

  task automatic t_single_start;
    wr(ADDR_DUTY_A, 16'h0008);
    wr(ADDR_DUTY_B, 16'h000C);
    wr(ADDR_DUTY_C, 16'h0005);
    repeat (40) @(posedge core_clk);
    #1;
    chk("gates before start", 16'h0000, {10'h000, gate});
    chk("sync before start", 16'h0000, {15'h0000, cycle_sync_pulse});
    wr(ADDR_DEAD_TIME, 16'h0002);
    wr(ADDR_SYNC_WIDTH, 16'h0003);
    wr(ADDR_HALF_PER, 16'h0014);
    first_sync(31);
    wait_sync(2);
    chk("period length", 16'h0028, len_seen);
    chk("sync width", 16'h0004, sync_w_seen);
    chk_pairs(12, 20, 20, 12, 6, 26);
  endtask : t_single_start

  task automatic t_single_shapes;
    wr(ADDR_DUTY_A, 16'h0009);
    wr(ADDR_DUTY_B, 16'h0000);
    wr(ADDR_DUTY_C, 16'h0019);
    wait_sync(2);
    chk_pairs(14, 18, 0, 36, 40, 0);
  endtask : t_single_shapes

  task automatic t_min_pulse;
    wr(ADDR_MIN_PULSE, 16'h0004);
    wr(ADDR_DUTY_A, 16'h0005);
    wr(ADDR_DUTY_B, 16'h0011);
    wr(ADDR_DUTY_C, 16'h000A);
    wait_sync(2);
    chk_pairs(0, 40, 40, 0, 16, 16);
  endtask : t_min_pulse

  task automatic t_double;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] l1;
    logic [15:0] h1;
    wr(ADDR_MIN_PULSE, 16'h0000);
    wr(ADDR_MODE_CTRL, 16'h0040);
    wr(ADDR_DUTY_A, 16'h0008);
    wr(ADDR_DUTY_B, 16'h0008);
    wr(ADDR_DUTY_C, 16'h0008);
    wait_sync(3);
    chk("half interval", 16'h0014, len_seen);
    chk_pairs(6, 10, 6, 10, 6, 10);
    rd(ADDR_SYS_STATUS, s1);
    wait_sync(1);
    rd(ADDR_SYS_STATUS, s2);
    chk("half flag toggles", {15'h0000, ~s1[3]}, {15'h0000, s2[3]});
    wr(ADDR_HALF_PER, 16'h001E);
    wr(ADDR_DUTY_A, 16'h000C);
    wait_sync(2);
    l1 = len_seen;
    h1 = on_seen[0];
    wr(ADDR_HALF_PER, 16'h0014);
    wr(ADDR_DUTY_A, 16'h0004);
    wait_sync(2);
    chk("period sum", 16'h0032, l1 + len_seen);
    chk("high sum", 16'h000C, h1 + on_seen[0]);
  endtask : t_double

  task automatic t_double_start;
    do_reset();
    wr(ADDR_MODE_CTRL, 16'h0040);
    wr(ADDR_DUTY_A, 16'h0008);
    wr(ADDR_DUTY_B, 16'h0008);
    wr(ADDR_DUTY_C, 16'h0008);
    wr(ADDR_HALF_PER, 16'h0014);
    first_sync(21);
  endtask : t_double_start

  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Whole run is well under 2000 cycles; 20000 leaves ample margin
  initial
  begin
    #800000;
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    rst        = 1'b1;
    reg_addr   = 4'h0;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    fail_count = 0;
    checked    = 0;
    do_reset();
    #1;
    chk("gates in reset", 16'h0000, {10'h000, gate});
    t_defaults();
    t_single_start();
    t_single_shapes();
    t_min_pulse();
    t_double();
    t_double_start();
    tally_and_finish();
  end
endmodule : three_phase_center_pwm_timing_bench
